// *** shared/amcs_pkg.sv ***
// amcs_pkg: constants and carriers for the alternate master chip select block
// assumes bank settings arrive as plain ports, one struct per bank
package amcs_pkg;
    localparam int NUM_BANKS = 8;
    localparam int ADDR_W = 28;
    localparam int WS_W = 4;
    // transfer size codes
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;
    // port size codes
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_8 = 2'h1;
    localparam logic [1:0] PORT_16 = 2'h2;
    // reset values
    localparam logic [3:0] CS_IDLE_N = 4'hF;
    localparam logic [7:0] BANK_IDLE_N = 8'hFF;
    localparam logic [3:0] WS_ZERO = 4'h0;
    localparam logic [3:0] BEATS_ONE = 4'h1;

    typedef enum logic [2:0] {
        AMCS_IDLE = 3'b000,
        AMCS_DECODE = 3'b001,
        AMCS_BEAT = 3'b010,
        AMCS_GAP = 3'b011,
        AMCS_END = 3'b100,
        AMCS_RELEASE = 3'b101
    } amcs_state_e;

    // per-bank settings
    typedef struct packed {
        logic [15:0] base_addr;    // compares with address bits 31:16
        logic [15:0] addr_mask;    // 1 = bit ignored, bits 11:0 only; bits 15:12 have no effect
        logic [3:0] wait_state_count;
        logic burst_en;
        logic addr_setup;
        logic write_addr_hold;
        logic read_addr_hold;
        logic ext_master_auto_ack;
        logic [1:0] port_size;
        logic write_en;
        logic read_en;
    } amcs_bank_s;

    // default memory control settings
    typedef struct packed {
        logic [3:0] wait_state_count;
        logic burst_en;
        logic ext_master_auto_ack;
        logic [1:0] port_size;
    } amcs_dflt_s;

    // attributes captured at transfer start
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic read;
        logic [1:0] size;
    } amcs_xfer_s;
endpackage

// *** verilog/amcs_alt_master_cs.sv ***
// amcs_alt_master_cs: chip select and auto-acknowledge for alternate master cycles
// assumes pins are already synchronised to clk_sys, bank settings are static during a cycle
//
// Contract
// - while bus granted away, watch transfer_start_n and produce selects and acknowledge.
// - capture 28-bit address, direction and size on the start edge.
// - force upper four address bits to zero when those pins are not address.
// - transfer type and access mode inputs are not looked at.
// - privilege and interrupt-acknowledge mask bits are not applied.
// - control sequence starts on the edge after capture.
// - matched bank enabled for direction gets chip select and write enables.
// - matched bank with auto acknowledge drives and asserts transfer_ack_n.
// - address bus is never driven during these cycles.
// - unmatched address outside DRAM with default auto acknowledge gets ack after its wait states.
// - burst-enabled region with size above port width is sequenced as a burst.
// - after last beat negate select and ack, then release ack next edge.
// - burst without setup or hold keeps select asserted across beats, and ack too when wait states are zero.
// - setup and hold settings ignored for non-burst transfers.
// - burst reads insert one negated clock per setup and read-hold bit.
// - burst writes insert one negated clock per setup and write-hold bit.
// - with setup or hold, negate select and ack during gap, reassert after.
// - write enables stay negated on zero wait state writes.
`timescale 1ns/1ps
module amcs_alt_master_cs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic bus_granted_away,
    input wire logic transfer_start_n,
    input wire logic [27:0] addr_in,
    input wire logic read_write,
    input wire logic [1:0] transfer_size,
    input wire logic [1:0] transfer_type,
    input wire logic access_type_mode,
    input wire logic upper_addr_is_addr,
    input wire logic dram_hit,
    input amcs_pkg::amcs_bank_s [7:0] bank_control_settings,
    input amcs_pkg::amcs_dflt_s default_memory_control,
    output logic [7:0] chip_select_n,
    output logic [3:0] write_enable_n,
    output logic transfer_ack_n_out,
    output logic transfer_ack_n_oe,
    output logic addr_oe
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // beats needed when the transfer is wider than the port
    function automatic logic [3:0] beat_count(input logic [1:0] size, input logic [1:0] port);
        logic [3:0] bytes;
        logic [3:0] width;
        bytes = 4'h1;
        width = 4'h4;
        case (size)
            amcs_pkg::SIZE_BYTE: bytes = 4'h1;
            amcs_pkg::SIZE_WORD: bytes = 4'h2;
            default: bytes = 4'h4;
        endcase
        case (port)
            amcs_pkg::PORT_8: width = 4'h1;
            amcs_pkg::PORT_16: width = 4'h2;
            default: width = 4'h4;
        endcase
        if (bytes > width) begin
            beat_count = (width == 4'h1) ? bytes : 4'(bytes >> 1);
        end else begin
            beat_count = amcs_pkg::BEATS_ONE;
        end
        // line transfers take four beats on a 32-bit port and fifteen on narrower ports
        if (size == amcs_pkg::SIZE_LINE) begin
            beat_count = (width == 4'h4) ? 4'h4 : 4'hF;
        end
    endfunction

    // byte lanes used by the first beat
    function automatic logic [3:0] lane_mask(input logic [1:0] port);
        case (port)
            amcs_pkg::PORT_8: lane_mask = 4'h8;
            amcs_pkg::PORT_16: lane_mask = 4'hC;
            default: lane_mask = 4'hF;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // start detection and capture

    logic start_seen;
    amcs_pkg::amcs_xfer_s xfer_now;
    logic [7:0] hit_vec;
    // transfer_type and access_type_mode deliberately unused
    // privilege mask bits are not part of the bank match

    assign start_seen = bus_granted_away && !transfer_start_n;
    always_comb begin
        xfer_now.addr = addr_in;
        if (!upper_addr_is_addr) begin
            xfer_now.addr[27:24] = 4'h0;
        end
        xfer_now.read = read_write;
        xfer_now.size = transfer_size;
    end

    amcs_pkg::amcs_xfer_s xfer_reg, xfer_next;
    amcs_pkg::amcs_state_e state_reg, state_next;
    logic [2:0] bank_reg, bank_next;
    logic dflt_reg, dflt_next;
    logic [3:0] beats_reg, beats_next;
    logic [3:0] wait_reg, wait_next;
    logic [1:0] gap_reg, gap_next;
    logic [3:0] ws_reg, ws_next;
    logic ack_en_reg, ack_en_next;
    logic [3:0] lanes_reg, lanes_next;
    logic [7:0] cs_n_reg, cs_n_next;
    logic [3:0] we_n_reg, we_n_next;
    logic ack_n_reg, ack_n_next;
    logic ack_oe_reg, ack_oe_next;

    genvar gi;
    generate
        for (gi = 0; gi < amcs_pkg::NUM_BANKS; gi++) begin : g_hit
            assign hit_vec[gi] = (((xfer_reg.addr[27:16] ^ bank_control_settings[gi].base_addr[11:0])
                & ~bank_control_settings[gi].addr_mask[11:0]) == 12'h000)
                && (bank_control_settings[gi].base_addr[15:12] == 4'h0)
                && (xfer_reg.read ? bank_control_settings[gi].read_en
                                  : bank_control_settings[gi].write_en);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    // gap clocks for the current direction; setup and hold only count in bursts
    logic [1:0] gap_len;
    amcs_pkg::amcs_bank_s sel_bank;
    always_comb begin
        sel_bank = bank_control_settings[bank_reg];
        gap_len = 2'(sel_bank.addr_setup)
            + 2'(xfer_reg.read ? sel_bank.read_addr_hold : sel_bank.write_addr_hold);
        if (dflt_reg) begin
            gap_len = 2'h0;
        end
    end

    always_comb begin
        state_next = state_reg;
        xfer_next = xfer_reg;
        bank_next = bank_reg;
        dflt_next = dflt_reg;
        beats_next = beats_reg;
        wait_next = wait_reg;
        gap_next = gap_reg;
        ws_next = ws_reg;
        ack_en_next = ack_en_reg;
        lanes_next = lanes_reg;
        cs_n_next = amcs_pkg::BANK_IDLE_N;
        we_n_next = amcs_pkg::CS_IDLE_N;
        ack_n_next = 1'b1;
        ack_oe_next = ack_oe_reg;
        case (state_reg)
            amcs_pkg::AMCS_IDLE: begin
                ack_oe_next = 1'b0;
                if (start_seen) begin
                    xfer_next = xfer_now;
                    state_next = amcs_pkg::AMCS_DECODE;
                end
            end
            amcs_pkg::AMCS_DECODE: begin
                state_next = amcs_pkg::AMCS_IDLE;
                dflt_next = 1'b0;
                bank_next = 3'h0;
                for (int i = amcs_pkg::NUM_BANKS - 1; i >= 0; i--) begin
                    if (hit_vec[i]) begin
                        bank_next = 3'(i);
                    end
                end
                if (hit_vec != 8'h00) begin
                    ws_next = bank_control_settings[bank_next].wait_state_count;
                    ack_en_next = bank_control_settings[bank_next].ext_master_auto_ack;
                    lanes_next = lane_mask(bank_control_settings[bank_next].port_size);
                    beats_next = bank_control_settings[bank_next].burst_en
                        ? beat_count(xfer_reg.size, bank_control_settings[bank_next].port_size)
                        : amcs_pkg::BEATS_ONE;
                    state_next = amcs_pkg::AMCS_BEAT;
                end else if (!dram_hit) begin
                    dflt_next = 1'b1;
                    ws_next = default_memory_control.wait_state_count;
                    ack_en_next = default_memory_control.ext_master_auto_ack;
                    lanes_next = lane_mask(default_memory_control.port_size);
                    beats_next = default_memory_control.burst_en
                        ? beat_count(xfer_reg.size, default_memory_control.port_size)
                        : amcs_pkg::BEATS_ONE;
                    state_next = amcs_pkg::AMCS_BEAT;
                end
                wait_next = ws_next;
                ack_oe_next = (state_next == amcs_pkg::AMCS_BEAT) && ack_en_next;
            end
            amcs_pkg::AMCS_BEAT: begin
                if (wait_reg != amcs_pkg::WS_ZERO) begin
                    wait_next = wait_reg - 4'h1;
                end else begin
                    wait_next = ws_reg;
                    if (beats_reg == amcs_pkg::BEATS_ONE) begin
                        state_next = amcs_pkg::AMCS_END;
                    end else begin
                        beats_next = beats_reg - 4'h1;
                        gap_next = gap_len;
                        // without setup or hold the next beat follows directly
                        if (gap_len != 2'h0) begin
                            state_next = amcs_pkg::AMCS_GAP;
                        end
                    end
                end
            end
            amcs_pkg::AMCS_GAP: begin
                // select and ack negated while the master moves the address
                gap_next = gap_reg - 2'h1;
                if (gap_reg == 2'h1) begin
                    state_next = amcs_pkg::AMCS_BEAT;
                end
            end
            amcs_pkg::AMCS_END: begin
                // ack stays driven high for this one clock only, then floats
                ack_oe_next = 1'b0;
                state_next = amcs_pkg::AMCS_RELEASE;
            end
            amcs_pkg::AMCS_RELEASE: begin
                ack_oe_next = 1'b0;
                state_next = amcs_pkg::AMCS_IDLE;
            end
            default: begin
                state_next = amcs_pkg::AMCS_IDLE;
                ack_oe_next = 1'b0;
            end
        endcase
        // outputs are registered, so they are decoded from the state being entered;
        // this puts the select in the clock right after decode, not one later
        if (state_next == amcs_pkg::AMCS_BEAT) begin
            if (!dflt_next) begin
                cs_n_next[bank_next] = 1'b0;
            end
            // zero wait writes never strobe the write enables
            if (!xfer_next.read && !dflt_next && ws_next != amcs_pkg::WS_ZERO) begin
                we_n_next = ~lanes_next;
            end
            if (wait_next == amcs_pkg::WS_ZERO) begin
                ack_n_next = !ack_en_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= amcs_pkg::AMCS_IDLE;
            xfer_reg <= '0;
            bank_reg <= 3'h0;
            dflt_reg <= 1'b0;
            beats_reg <= amcs_pkg::BEATS_ONE;
            wait_reg <= amcs_pkg::WS_ZERO;
            gap_reg <= 2'h0;
            ws_reg <= amcs_pkg::WS_ZERO;
            ack_en_reg <= 1'b0;
            lanes_reg <= 4'h0;
            cs_n_reg <= amcs_pkg::BANK_IDLE_N;
            we_n_reg <= amcs_pkg::CS_IDLE_N;
            ack_n_reg <= 1'b1;
            ack_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            xfer_reg <= xfer_next;
            bank_reg <= bank_next;
            dflt_reg <= dflt_next;
            beats_reg <= beats_next;
            wait_reg <= wait_next;
            gap_reg <= gap_next;
            ws_reg <= ws_next;
            ack_en_reg <= ack_en_next;
            lanes_reg <= lanes_next;
            cs_n_reg <= cs_n_next;
            we_n_reg <= we_n_next;
            ack_n_reg <= ack_n_next;
            ack_oe_reg <= ack_oe_next;
        end
    end

    assign chip_select_n = cs_n_reg;
    assign write_enable_n = we_n_reg;
    assign transfer_ack_n_out = ack_n_reg;
    assign transfer_ack_n_oe = ack_oe_reg;
    // address pins belong to the alternate master here
    assign addr_oe = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_addr_never_driven: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !addr_oe) else $error("address driven during alternate master cycle");
    a_start_to_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == amcs_pkg::AMCS_IDLE && start_seen) |=> state_reg == amcs_pkg::AMCS_DECODE
        && xfer_reg.size == $past(transfer_size)) else $error("start not captured");
    a_upper_zeroed: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == amcs_pkg::AMCS_IDLE && start_seen && !upper_addr_is_addr)
        |=> xfer_reg.addr[27:24] == 4'h0) else $error("upper address not zeroed");
    a_cs_after_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == amcs_pkg::AMCS_DECODE && hit_vec != 8'h00 && wait_next == 4'h0)
        |=> chip_select_n != amcs_pkg::BANK_IDLE_N) else $error("select late");
    a_ack_negate_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == amcs_pkg::AMCS_END) |-> ##0 transfer_ack_n_out && chip_select_n == 8'hFF
        ##1 !transfer_ack_n_oe) else $error("ack not released after end");
    a_no_zero_ws_we: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ws_reg == 4'h0) |-> write_enable_n == 4'hF) else $error("write enable on zero wait");
    a_gap_negates: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == amcs_pkg::AMCS_GAP) |-> chip_select_n == 8'hFF && transfer_ack_n_out)
        else $error("select asserted in gap");
    a_ack_needs_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !transfer_ack_n_out |-> transfer_ack_n_oe) else $error("ack low while not driven");
    a_wait_delays_ack: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == amcs_pkg::AMCS_BEAT && wait_reg != 4'h0) |-> transfer_ack_n_out)
        else $error("ack before wait states elapsed");
endmodule

// *** test/amcs_alt_master_model.sv ***
// amcs_alt_master_model: behavioural alternate bus master facing the chip select block
// assumes the bench raises go for one cycle at a falling edge; the ack wire has a pull-up
// a new go restarts the master, so a start that the block ignored cannot wedge it
`timescale 1ns/1ps
module amcs_alt_master_model (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [27:0] go_addr,
    input wire logic go_read,
    input wire logic [1:0] go_size,
    input wire logic [27:0] go_step,
    input wire logic [3:0] go_beats,
    input wire logic transfer_ack_n,
    output logic transfer_start_n,
    output logic [27:0] addr_in,
    output logic read_write,
    output logic [1:0] transfer_size
);
    logic active = 1'b0;
    logic ack_seen = 1'b0;
    logic [3:0] left = 4'h0;
    initial begin
        transfer_start_n = 1'b1;
        addr_in = 28'h0;
        read_write = 1'b1;
        transfer_size = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // ack is sampled on the rising edge and acted on at the next falling edge
    always @(posedge clk_sys) begin
        ack_seen <= active && (transfer_ack_n === 1'b0);
    end
    always @(negedge clk_sys) begin
        transfer_start_n <= !go;
        if (go) begin
            addr_in <= go_addr;
            read_write <= go_read;
            transfer_size <= go_size;
            left <= go_beats;
            active <= 1'b1;
        end else if (active && ack_seen) begin
            addr_in <= addr_in + go_step;
            left <= left - 4'h1;
            active <= (left != 4'h1);
        end else if (!active) begin
            // released bus keeps changing so a stale address never looks valid
            addr_in <= ~addr_in;
        end
    end
endmodule

// *** test/amcs_alt_master_cs_tb.sv ***
// amcs_alt_master_cs_tb: self-checking bench for alternate master chip select timing
// assumes amcs_pkg is compiled first and the master model drives the transfer pins
`timescale 1ns/1ps
module amcs_alt_master_cs_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_granted_away = 1'b1;
    logic upper_addr_is_addr = 1'b1;
    logic dram_hit = 1'b0;
    logic [1:0] transfer_type = 2'h0;
    logic access_type_mode = 1'b0;
    amcs_pkg::amcs_bank_s [7:0] banks = '0;
    amcs_pkg::amcs_dflt_s dflt = '0;
    logic go = 1'b0;
    logic [27:0] go_addr = 28'h0;
    logic go_read = 1'b1;
    logic [1:0] go_size = 2'h0;
    logic [3:0] go_beats = 4'h1;
    logic transfer_start_n;
    logic [27:0] addr_in;
    logic read_write;
    logic [1:0] transfer_size;
    logic [7:0] chip_select_n;
    logic [3:0] write_enable_n;
    logic ack_out;
    logic ack_oe;
    logic addr_oe;
    // released ack floats high through the board pull-up
    wire logic ack_wire = ack_oe ? ack_out : 1'b1;
    int fail_count = 0;
    int samples_checked = 0;
    always #20 clk_sys = ~clk_sys;
    amcs_alt_master_model u_master (.clk_sys(clk_sys), .go(go), .go_addr(go_addr),
        .go_read(go_read), .go_size(go_size), .go_step(28'h2), .go_beats(go_beats),
        .transfer_ack_n(ack_wire), .transfer_start_n(transfer_start_n), .addr_in(addr_in),
        .read_write(read_write), .transfer_size(transfer_size));
    amcs_alt_master_cs u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .bus_granted_away(bus_granted_away), .transfer_start_n(transfer_start_n),
        .addr_in(addr_in), .read_write(read_write), .transfer_size(transfer_size),
        .transfer_type(transfer_type), .access_type_mode(access_type_mode),
        .upper_addr_is_addr(upper_addr_is_addr), .dram_hit(dram_hit),
        .bank_control_settings(banks), .default_memory_control(dflt),
        .chip_select_n(chip_select_n), .write_enable_n(write_enable_n),
        .transfer_ack_n_out(ack_out), .transfer_ack_n_oe(ack_oe), .addr_oe(addr_oe));
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one transfer; bit j of each mask is cycle C2+j, an unknown select counts as active
    task xfer(input logic [27:0] a, input logic rd, input logic [1:0] sz, input logic [3:0] nb,
              input logic [15:0] ecs, input logic [15:0] eack, input logic [15:0] eoe,
              input logic [7:0] cs1, input logic [3:0] we1);
        logic [15:0] mcs;
        logic [15:0] mack;
        logic [15:0] moe;
        logic [7:0] scs;
        logic [3:0] swe;
        logic aoe;
        mcs = '0;
        mack = '0;
        moe = '0;
        scs = 8'h00;
        swe = 4'h0;
        aoe = 1'b0;
        go_addr <= a;
        go_read <= rd;
        go_size <= sz;
        go_beats <= nb;
        go <= 1'b1;
        @(negedge clk_sys);
        go <= 1'b0;
        for (int j = 0; j < 16; j++) begin
            @(negedge clk_sys);
            mcs[j] = (chip_select_n !== 8'hFF);
            mack[j] = (ack_wire === 1'b0);
            moe[j] = (ack_oe === 1'b1);
            aoe = aoe | (addr_oe !== 1'b0);
            if (j == 1) begin
                scs = chip_select_n;
                swe = write_enable_n;
            end
        end
        cmp("cs_active", ecs, mcs);
        cmp("ack_low", eack, mack);
        cmp("ack_drive", eoe, moe);
        cmp("cs_bank", {8'h00, cs1}, {8'h00, scs});
        cmp("we_lanes", {12'h000, we1}, {12'h000, swe});
        cmp("addr_drive", 16'h0000, {15'h0000, aoe});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
    initial begin
        for (int b = 0; b < 4; b++) begin
            banks[b].base_addr = 16'(b);
            banks[b].ext_master_auto_ack = 1'b1;
            banks[b].read_en = (b != 2);
            banks[b].write_en = 1'b1;
        end
        banks[1].port_size = amcs_pkg::PORT_16;
        banks[1].burst_en = 1'b1;
        banks[3].wait_state_count = 4'h2;
        dflt.wait_state_count = 4'h3;
        dflt.ext_master_auto_ack = 1'b1;
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        cmp("cs_reset", 16'h00FF, {8'h00, chip_select_n});
        cmp("ack_oe_reset", 16'h0000, {15'h0000, ack_oe});
        xfer(28'h0000010, 1, 2'h0, 1, 16'h0002, 16'h0002, 16'h0006, 8'hFE, 4'hF);
        bus_granted_away = 1'b0;
        xfer(28'h0000010, 1, 2'h0, 1, 16'h0000, 16'h0000, 16'h0000, 8'hFF, 4'hF);
        bus_granted_away = 1'b1;
        upper_addr_is_addr = 1'b0;
        transfer_type = 2'h3;
        access_type_mode = 1'b1;
        xfer(28'hA000010, 1, 2'h0, 1, 16'h0002, 16'h0002, 16'h0006, 8'hFE, 4'hF);
        upper_addr_is_addr = 1'b1;
        xfer(28'h0010000, 1, 2'h0, 2, 16'h0006, 16'h0006, 16'h000E, 8'hFD, 4'hF);
        banks[1].addr_setup = 1'b1;
        banks[1].read_addr_hold = 1'b1;
        xfer(28'h0010000, 1, 2'h0, 2, 16'h0012, 16'h0012, 16'h003E, 8'hFD, 4'hF);
        xfer(28'h0010000, 0, 2'h0, 2, 16'h000A, 16'h000A, 16'h001E, 8'hFD, 4'hF);
        banks[1].burst_en = 1'b0;
        xfer(28'h0010000, 1, 2'h2, 1, 16'h0002, 16'h0002, 16'h0006, 8'hFD, 4'hF);
        xfer(28'h0030000, 0, 2'h0, 1, 16'h000E, 16'h0008, 16'h001E, 8'hF7, 4'h0);
        xfer(28'h0020000, 1, 2'h0, 1, 16'h0000, 16'h0010, 16'h003E, 8'hFF, 4'hF);
        dram_hit = 1'b1;
        xfer(28'h0400000, 1, 2'h0, 1, 16'h0000, 16'h0000, 16'h0000, 8'hFF, 4'hF);
        end_of_test();
    end
endmodule
